// ==== hw/boot_fetch_defs.svh ====
`ifndef BOOT_FETCH_DEFS_SVH
`define BOOT_FETCH_DEFS_SVH
`define CMD_ADDR_FIRST 24'h000008
`define CMD_ADDR_STEP 24'h000008
`define CLK_PERIOD_NS 5
`define ADV_TO_DATA_NS 220
`define LOAD_DLY 8'h2c
`define EARLY_DLY 8'h2d
`define LATE_DLY 8'h2e
`define DONE_DLY 8'h30
`define BRANCH_CODE 4'h8
`endif

// ==== hw/boot_fetch_pkg.sv ====
package boot_fetch_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_REQ = 4'h1,
		ST_RESP = 4'h3,
		ST_ADV = 4'h2,
		ST_STROBE = 4'h6,
		ST_WAIT_AIN = 4'h7,
		ST_CHECK_UA = 4'h5,
		ST_CMD = 4'h4,
		ST_CMD_OUT = 4'hc,
		ST_DONE = 4'hd,
		ST_HALT = 4'h8
	} boot_state_e;

	typedef struct packed {
		logic [7:0] command;
		logic command_par;
		logic [23:0] data_addr;
		logic [2:0] data_addr_par;
		logic [4:0] flags;
		logic flags_par;
		logic [15:0] count;
		logic [1:0] count_par;
	} ccw_regs_s;

	typedef struct packed {
		logic [7:0] data;
		logic par;
	} bus_byte_s;

	typedef struct packed {
		logic req;
		logic [23:0] addr;
		logic addr_valid;
	} storage_req_s;
endpackage

// ==== hw/strobe_delay.sv ====
`timescale 1ns/100ps
`include "boot_fetch_defs.svh"
// derives one delayed strobe per tap from a single advance pulse
module strobe_delay import boot_fetch_pkg::*; #(
	parameter int TAPS = 4,
	parameter int CW = 8
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic [TAPS*CW-1:0] i_delays,
	output logic [TAPS-1:0] o_strobe
);
	typedef struct packed {
		logic run;
		logic [CW-1:0] cnt;
	} dly_state_s;
	dly_state_s s_q, s_d;

	initial begin
		if (TAPS < 1 || CW < 2)
			$error("strobe_delay: bad parameters");
	end

	always_comb begin
		s_d = s_q;
		if (i_start) begin
			s_d.run = 1'b1;
			s_d.cnt = '0;
		end else if (s_q.run) begin
			s_d.cnt = s_q.cnt + 1'b1;
			if (s_q.cnt == {CW{1'b1}})
				s_d.run = 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// each tap is a compare, so strobes stay one cycle wide
	genvar g;
	generate
		for (g = 0; g < TAPS; g++) begin : g_tap
			assign o_strobe[g] = s_q.run &&
				(s_q.cnt == i_delays[g*CW +: CW]);
		end
	endgenerate
endmodule // strobe_delay

// ==== hw/boot_ccw_fetch.sv ====
`timescale 1ns/100ps
`include "boot_fetch_defs.svh"
// Notes on behaviour
// - boot fetches first command word doubleword from address eight
// - storage request sets storage-cycle latch held until cycle completes
// - adder gets command address plus eight; register unchanged till end
// - controller answers request; address driven only while response high
// - falling response edge latches adder result sixteen for later use
// - advance pulse yields load, early, late and complete strobes
// - load strobe splits word into command, address, flag, count
// - early strobe: branch command sets branch latches, program check
// - late strobe: reserved bits nonzero or count zero is check
// - no check: set word-valid, clear fetch latch after late strobe
// - late strobe moves incremented address into command address
// - second fetch flag set when either of the top two flag bits (chain flags) is set
// - gated address-in is address-in and valid; clock on with op-in
// - gated address-in samples unit byte; even parity is check
// - good parity unit byte compared; mismatch is interface check
// - command start: clear setup, run clock, gate command, check parity
// - low address bits go to byte counter, added to count, cleared
// - flip address byte parity if clearing bits changes parity
// - raise command-out, unit drops address-in, then drop command-out
// - any check halts the boot until manual restart
// - command-out rises at clock phase seven with good command parity
module boot_ccw_fetch import boot_fetch_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_restart,
	input wire logic [7:0] i_unit_addr,
	input wire logic [31:0] i_delays,
	input wire logic i_storage_response,
	input wire logic i_storage_advance,
	input wire logic [63:0] i_storage_output_bus,
	input wire logic [7:0] i_storage_output_par,
	input wire logic i_address_in,
	input wire logic i_operational_in,
	input wire bus_byte_s i_bus_in,
	output storage_req_s o_storage,
	output logic o_command_out,
	output logic o_ccw_valid,
	output logic o_program_check,
	output logic o_if_control_check,
	output logic o_branch_latch,
	output logic o_gate_command,
	output logic o_clock_run,
	output logic o_second_fetch,
	output logic [23:0] o_cmd_addr,
	output ccw_regs_s o_ccw,
	output logic [2:0] o_byte_counter
);
	typedef struct packed {
		boot_state_e st;
		logic storage_req;
		logic storage_cycle;
		logic ccw_fetch;
		logic gate_adder;
		logic resp_prev;
		logic [23:0] cmd_addr;
		logic [23:0] adder_latch;
		ccw_regs_s ccw;
		logic ccw_valid;
		logic prog_check;
		logic if_check;
		logic branch;
		logic branch_cycle;
		logic setup;
		logic gate_cmd;
		logic clock_run;
		logic [2:0] phase;
		logic cmd_out;
		logic [2:0] byte_cnt;
		logic second_fetch;
	} boot_state_s;
	boot_state_s s_q, s_d;

	localparam int ADV_CYCLES = (`ADV_TO_DATA_NS / `CLK_PERIOD_NS);
	logic [3:0] strobe;
	logic gated_ain;
	logic halted;
	logic [18:0] count_sum;

	initial begin
		if (ADV_CYCLES < 1)
			$error("boot_ccw_fetch: advance delay under one cycle");
	end

	function automatic logic odd_par(input logic [7:0] b, input logic p);
		return ^{b, p};
	endfunction

	strobe_delay #(
		.TAPS(4),
		.CW(8)
	) u_strobes (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_start(i_storage_advance && s_q.storage_cycle),
		.i_delays(i_delays),
		.o_strobe(strobe)
	);

	assign gated_ain = i_address_in && s_q.ccw_valid;
	assign halted = s_q.prog_check || s_q.if_check;
	assign count_sum = {3'h0, s_q.ccw.count} + {16'h0, s_q.ccw.data_addr[2:0]};

	always_comb begin
		s_d = s_q;
		s_d.resp_prev = i_storage_response;
		if (s_q.clock_run)
			s_d.phase = s_q.phase + 3'h1;
		if (i_restart) begin
			s_d = '0;
			s_d.cmd_addr = `CMD_ADDR_FIRST;
			s_d.resp_prev = i_storage_response;
		end else if (halted) begin
			s_d.st = ST_HALT;
			s_d.storage_req = 1'b0;
			s_d.cmd_out = 1'b0;
			s_d.clock_run = 1'b0;
		end else begin
			case (s_q.st)
				ST_IDLE: begin
					if (i_start) begin
						s_d.cmd_addr = `CMD_ADDR_FIRST;
						s_d.ccw_fetch = 1'b1;
						s_d.storage_req = 1'b1;
						s_d.storage_cycle = 1'b1;
						s_d.setup = 1'b1;
						s_d.ccw_valid = 1'b0;
						s_d.st = ST_REQ;
					end
				end
				ST_REQ: begin
					s_d.gate_adder = s_q.ccw_fetch;
					if (i_storage_response) begin
						s_d.storage_req = 1'b0;
						s_d.st = ST_RESP;
					end
				end
				ST_RESP: begin
					if (!i_storage_response && s_q.resp_prev) begin
						s_d.adder_latch = s_q.cmd_addr + `CMD_ADDR_STEP;
						s_d.st = ST_ADV;
					end
				end
				ST_ADV: begin
					if (i_storage_advance)
						s_d.st = ST_STROBE;
				end
				ST_STROBE: begin
					if (strobe[0]) begin
						s_d.ccw.command = i_storage_output_bus[63:56];
						s_d.ccw.command_par = i_storage_output_par[7];
						s_d.ccw.data_addr = i_storage_output_bus[55:32];
						s_d.ccw.data_addr_par = i_storage_output_par[6:4];
						s_d.ccw.flags = i_storage_output_bus[31:27];
						s_d.ccw.flags_par = i_storage_output_par[3];
						s_d.ccw.count = i_storage_output_bus[15:0];
						s_d.ccw.count_par = i_storage_output_par[1:0];
					end
					if (strobe[1] && i_storage_output_bus[59:56]
						== `BRANCH_CODE) begin
						s_d.branch = 1'b1;
						s_d.branch_cycle = 1'b1;
						s_d.prog_check = 1'b1;
					end
					if (strobe[2]) begin
						s_d.cmd_addr = s_q.adder_latch;
						s_d.gate_adder = 1'b0;
						if (i_storage_output_bus[26:25] != 2'h0 ||
							i_storage_output_bus[15:0] == 16'h0)
							s_d.prog_check = 1'b1;
						else begin
							s_d.ccw_valid = 1'b1;
							s_d.ccw_fetch = 1'b0;
							s_d.second_fetch = i_storage_output_bus[31] ||
								i_storage_output_bus[30];
						end
					end
					if (strobe[3]) begin
						s_d.storage_cycle = 1'b0;
						s_d.st = ST_WAIT_AIN;
					end
				end
				ST_WAIT_AIN: begin
					if (gated_ain && i_operational_in) begin
						s_d.clock_run = 1'b1;
						s_d.phase = 3'h0;
						s_d.st = ST_CHECK_UA;
					end
				end
				ST_CHECK_UA: begin
					if (!odd_par(i_bus_in.data, i_bus_in.par))
						s_d.if_check = 1'b1;
					else if (i_bus_in.data != i_unit_addr)
						s_d.if_check = 1'b1;
					else begin
						s_d.setup = 1'b0;
						s_d.gate_cmd = 1'b1;
						s_d.clock_run = 1'b1;
						s_d.st = ST_CMD;
					end
				end
				ST_CMD: begin
					if (!odd_par(s_q.ccw.command, s_q.ccw.command_par))
						s_d.if_check = 1'b1;
					else if (s_q.phase == 3'h4) begin
						s_d.byte_cnt = s_q.ccw.data_addr[2:0];
						s_d.ccw.count = count_sum[15:0];
						s_d.ccw.count_par[0] = ~^count_sum[7:0];
						s_d.ccw.count_par[1] = ~^count_sum[15:8];
						s_d.ccw.data_addr_par[0] = s_q.ccw.data_addr_par[0]
							^ (^s_q.ccw.data_addr[2:0]);
						s_d.ccw.data_addr[2:0] = 3'h0;
					end else if (s_q.phase == 3'h7 && gated_ain) begin
						s_d.cmd_out = 1'b1;
						s_d.st = ST_CMD_OUT;
					end
				end
				ST_CMD_OUT: begin
					if (!i_address_in) begin
						s_d.cmd_out = 1'b0;
						s_d.clock_run = 1'b0;
						s_d.st = ST_DONE;
					end
				end
				ST_DONE: begin
				end
				default: begin
					s_d.st = ST_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	always_comb begin
		o_storage.req = s_q.storage_req;
		o_storage.addr_valid = i_storage_response && s_q.storage_cycle;
		o_storage.addr = (i_storage_response && s_q.storage_cycle) ?
			s_q.cmd_addr : 24'h0;
	end

	assign o_command_out = s_q.cmd_out;
	assign o_ccw_valid = s_q.ccw_valid;
	assign o_program_check = s_q.prog_check;
	assign o_if_control_check = s_q.if_check;
	assign o_branch_latch = s_q.branch;
	assign o_gate_command = s_q.gate_cmd;
	assign o_clock_run = s_q.clock_run;
	assign o_second_fetch = s_q.second_fetch;
	assign o_cmd_addr = s_q.cmd_addr;
	assign o_ccw = s_q.ccw;
	assign o_byte_counter = s_q.byte_cnt;

	property p_halt_holds;
		@(posedge i_clock) disable iff (!i_rst_n)
		(halted && !i_restart) |=> halted;
	endproperty
	a_halt_holds: assert property (p_halt_holds)
		else $error("check latch dropped without restart");

	property p_cmd_out_drop;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_q.st == ST_CMD_OUT && !i_address_in && !halted && !i_restart)
			|=> !o_command_out;
	endproperty
	a_cmd_out_drop: assert property (p_cmd_out_drop)
		else $error("command-out held after address-in dropped");

	property p_no_addr_update;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_q.st == ST_RESP) |=> $stable(s_q.cmd_addr);
	endproperty
	a_no_addr_update: assert property (p_no_addr_update)
		else $error("command address changed during fetch");

	property p_addr_bus;
		@(posedge i_clock) disable iff (!i_rst_n)
		!i_storage_response |-> o_storage.addr == 24'h0;
	endproperty
	a_addr_bus: assert property (p_addr_bus)
		else $error("address driven without response");

	property p_cycle_held;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_q.st inside {ST_REQ, ST_RESP, ST_ADV}) |-> s_q.storage_cycle;
	endproperty
	a_cycle_held: assert property (p_cycle_held)
		else $error("storage-cycle latch dropped mid-cycle");

	sequence s_resp_fall;
		s_q.st == ST_RESP && !i_storage_response && s_q.resp_prev;
	endsequence
	property p_adder_latch;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_resp_fall ##0 (!halted && !i_restart)) |=>
			(s_q.adder_latch == $past(s_q.cmd_addr) + `CMD_ADDR_STEP);
	endproperty
	a_adder_latch: assert property (p_adder_latch)
		else $error("adder result not latched on response fall");

	property p_branch_check;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_q.st == ST_STROBE && strobe[1] && !halted && !i_restart &&
			i_storage_output_bus[59:56] == `BRANCH_CODE) |=>
			(o_branch_latch && o_program_check);
	endproperty
	a_branch_check: assert property (p_branch_check)
		else $error("branch command in first word not flagged");

	property p_valid_on_late;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(s_q.ccw_valid) |-> $past(strobe[2]);
	endproperty
	a_valid_on_late: assert property (p_valid_on_late)
		else $error("word-valid rose without late strobe");

	property p_unit_check;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_q.st == ST_CHECK_UA && !halted && !i_restart &&
			i_bus_in.data != i_unit_addr) |=> o_if_control_check;
	endproperty
	a_unit_check: assert property (p_unit_check)
		else $error("unit address mismatch not flagged");

	// command-out waits for phase seven so the byte has settled on the bus
	sequence s_cmd_ready;
		s_q.st == ST_CMD && s_q.phase == 3'h7 && gated_ain;
	endsequence
	property p_cmd_out_rise;
		@(posedge i_clock) disable iff (!i_rst_n)
		(s_cmd_ready ##0 (!halted && !i_restart &&
			odd_par(s_q.ccw.command, s_q.ccw.command_par))) |=>
			o_command_out;
	endproperty
	a_cmd_out_rise: assert property (p_cmd_out_rise)
		else $error("command-out missing at phase seven");
endmodule // boot_ccw_fetch

// ==== verif/boot_partner.sv ====
`timescale 1ns/100ps
// storage controller and control unit, behavioural
module boot_partner import boot_fetch_pkg::*; (
	input wire logic i_clock,
	input wire logic i_slow,
	input wire logic [63:0] i_word,
	input wire logic [7:0] i_par,
	input wire bus_byte_s i_ua,
	input wire storage_req_s i_st,
	input wire logic i_valid,
	input wire logic i_cmd_out,
	input wire logic i_ifc,
	output logic o_resp,
	output logic o_adv,
	output logic [63:0] o_bus,
	output logic [7:0] o_par,
	output logic o_ain,
	output logic o_opin,
	output bus_byte_s o_bus_in
);
	int k;
	logic v_q;
	initial begin
		{o_resp, o_adv, o_ain, o_opin, v_q} = '0;
		o_bus = '1;
		o_par = '1;
		o_bus_in = '1;
	end
	// outside its window the bus shows the inverse, never a stale copy
	always begin
		@(negedge i_clock);
		if (i_st.req && !o_resp) begin
			repeat (i_slow ? 5 : 1) @(posedge i_clock);
			#1 o_resp = 1;
			repeat (i_slow ? 4 : 2) @(posedge i_clock);
			#1 o_resp = 0;
			repeat (i_slow ? 6 : 2) @(posedge i_clock);
			#1 o_adv = 1;
			@(posedge i_clock);
			#1 o_adv = 0;
			repeat (38) @(posedge i_clock);
			#1 o_bus = i_word;
			o_par = i_par;
			repeat (30) @(posedge i_clock);
			#1 o_bus = ~i_word;
			o_par = ~i_par;
		end
	end
	always begin
		@(negedge i_clock);
		if (i_valid && !v_q) begin
			repeat (2) @(posedge i_clock);
			#1 o_opin = 1;
			o_bus_in = i_ua;
			o_ain = 1;
			for (k = 0; k < 200 && !i_cmd_out && !i_ifc; k++)
				@(negedge i_clock);
			repeat (3) @(posedge i_clock);
			#1 o_ain = 0;
			o_opin = 0;
			o_bus_in = ~i_ua;
		end
		v_q = i_valid;
	end
endmodule // boot_partner

// ==== verif/boot_ccw_fetch_tb.sv ====
`timescale 1ns/100ps
`include "boot_fetch_defs.svh"
module boot_ccw_fetch_tb import boot_fetch_pkg::*;;
	logic clk, rst_n, start, restart, slow;
	logic resp, adv, ain, opin;
	logic [7:0] ua, spar, spar_bus;
	logic [63:0] sbus, word;
	bus_byte_s bin, ua_b;
	storage_req_s st;
	logic cmd_out, valid, pchk, ichk, br, gate, crun, sf;
	logic [23:0] caddr;
	ccw_regs_s ccw;
	logic [2:0] bc;
	int miscompares, total_checks;

	boot_ccw_fetch dut (.i_clock(clk), .i_rst_n(rst_n), .i_start(start),
		.i_restart(restart), .i_unit_addr(ua),
		.i_delays({`DONE_DLY, `LATE_DLY, `EARLY_DLY, `LOAD_DLY}),
		.i_storage_response(resp), .i_storage_advance(adv),
		.i_storage_output_bus(sbus), .i_storage_output_par(spar_bus),
		.i_address_in(ain), .i_operational_in(opin), .i_bus_in(bin),
		.o_storage(st), .o_command_out(cmd_out), .o_ccw_valid(valid),
		.o_program_check(pchk), .o_if_control_check(ichk),
		.o_branch_latch(br), .o_gate_command(gate), .o_clock_run(crun),
		.o_second_fetch(sf), .o_cmd_addr(caddr), .o_ccw(ccw),
		.o_byte_counter(bc));
	boot_partner far (.i_clock(clk), .i_slow(slow), .i_word(word),
		.i_par(spar), .i_ua(ua_b), .i_st(st), .i_valid(valid),
		.i_cmd_out(cmd_out), .i_ifc(ichk), .o_resp(resp), .o_adv(adv),
		.o_bus(sbus), .o_par(spar_bus), .o_ain(ain), .o_opin(opin),
		.o_bus_in(bin));

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// address bus carries the command address only while answered
	always @(negedge clk) begin
		if (rst_n && resp)
			chk({st.addr_valid, st.addr}, {1'b1, 24'h8});
		else if (rst_n)
			chk({st.addr_valid, st.addr}, 25'h0);
	end

	// kinds: 0 good, 1 slow storage, 2 branch, 3 reserved, 4 zero count,
	// 5 unit byte parity, 6 unit address mismatch, 7 command byte parity
	task automatic run(input int kind);
		logic [7:0] c;
		logic [23:0] a;
		logic [4:0] f;
		logic [10:0] r;
		logic [15:0] n;
		int k;
		c = 8'($urandom);
		c[3] = kind == 2;
		if (kind == 2)
			c[2:0] = 3'h0;
		a = 24'($urandom);
		f = 5'($urandom);
		r = 11'($urandom);
		r[10:9] = kind == 3 ? 2'b01 : 2'b00;
		n = kind == 4 ? 16'h0 : 16'($urandom) | 16'h1;
		@(posedge clk);
		#1 word = {c, a, f, r, n};
		spar = {~^c, ~^a[23:16], ~^a[15:8], ~^a[7:0], ~^f, 1'b1, ~^n[15:8],
			~^n[7:0]};
		spar[7] = spar[7] ^ (kind == 7);
		ua = 8'($urandom);
		ua_b.data = kind == 6 ? ~ua : ua;
		ua_b.par = kind == 5 ? ^ua_b.data : ~^ua_b.data;
		slow = kind == 1;
		start = 1;
		@(posedge clk);
		#1 start = 0;
		for (k = 0; k < 600 && !(valid | pchk); k++)
			@(negedge clk);
		if (kind >= 2 && kind <= 4) begin
			chk(pchk, 1);
			chk(valid, 0);
			chk(br, kind == 2);
			@(posedge clk);
			#1 start = 1;
			@(posedge clk);
			#1 start = 0;
			repeat (2) @(negedge clk);
			chk({st.req, pchk}, 2'b01);
		end else begin
			chk(valid, 1);
			chk(caddr, 24'h10);
			chk(sf, f[4] | f[3]);
			chk({ccw.command, ccw.flags}, {c, f});
			chk({ccw.data_addr, ccw.count}, {a, n});
			chk({ccw.command_par, ccw.data_addr_par, ccw.flags_par,
				ccw.count_par}, {spar[7:3], spar[1:0]});
			for (k = 0; k < 200 && !(cmd_out | ichk); k++)
				@(negedge clk);
			if (kind >= 5) begin
				chk({ichk, cmd_out}, 2'b10);
			end else begin
				chk({cmd_out, gate, crun}, 3'h7);
				chk(bc, a[2:0]);
				chk(ccw.count, 16'(n + a[2:0]));
				chk(ccw.data_addr, {a[23:3], 3'h0});
				chk(ccw.data_addr_par, spar[6:4] ^ {2'h0, ^a[2:0]});
				for (k = 0; k < 50 && cmd_out; k++)
					@(negedge clk);
				chk({cmd_out, ain, crun}, 3'h0);
			end
		end
		@(posedge clk);
		#1 restart = 1;
		@(posedge clk);
		#1 restart = 0;
		@(negedge clk);
		chk({pchk, ichk, br}, 3'h0);
	endtask

	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	// each run is under a hundred cycles; this is about thirty times the whole set
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end

	initial begin
		{rst_n, start, restart, slow} = '0;
		word = '0;
		spar = '0;
		ua = '0;
		ua_b = '0;
		miscompares = 0;
		total_checks = 0;
		void'($urandom(32'hf5d6d473));
		repeat (4) @(posedge clk);
		#1 rst_n = 1;
		for (int i = 0; i < 16; i++)
			run(i % 8);
		give_verdict();
	end
endmodule // boot_ccw_fetch_tb
